// >>> core/dccr_pkg.sv
package dccr_pkg;
  // register offsets inside one channel's window
  localparam logic [5:0] OFS_STATUS = 6'h00;
  localparam logic [5:0] OFS_ERROR = 6'h01;
  localparam logic [5:0] OFS_DEVCFG = 6'h04;
  localparam logic [5:0] OFS_OPCFG = 6'h05;
  localparam logic [5:0] OFS_SEQCFG = 6'h06;
  localparam logic [5:0] OFS_CMD = 6'h07;
  localparam logic [5:0] OFS_PRIO = 6'h2D;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] NULL_READ = 8'hFF;
  // field codes
  localparam logic [1:0] PRIO_0 = 2'h0;
  localparam logic [1:0] PRIO_1 = 2'h1;
  localparam logic [1:0] ASK_BURST = 2'h0;
  localparam logic [1:0] ASK_STEAL = 2'h2;
  localparam logic [1:0] PROTO_EXPLICIT = 2'h0;
  localparam logic [1:0] PROTO_SEL = 2'h2;
  localparam logic [1:0] PROTO_SELRDY = 2'h3;
  localparam logic [2:0] LINE_STATUS = 3'h0;
  localparam logic [2:0] LINE_STATUS_IRQ = 3'h1;
  localparam logic [2:0] LINE_ABORT = 3'h3;
  localparam logic [2:0] LINE_RELOAD = 3'h4;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] CHAIN_OFF = 2'h0;
  localparam logic [1:0] REQ_LIMITED = 2'h0;
  localparam logic [1:0] REQ_MAX = 2'h1;
  localparam logic [1:0] REQ_EXT = 2'h2;
  localparam logic [1:0] STEP_HOLD = 2'h0;
  localparam logic [1:0] STEP_UP = 2'h1;
  localparam logic [1:0] BYTES_1 = 2'h1;
  localparam logic [1:0] BYTES_2 = 2'h2;
  localparam logic [4:0] ERR_NONE = 5'h00;
  localparam logic [4:0] ERR_CONFIG = 5'h01;
  localparam logic [4:0] ERR_TIMING = 5'h02;
  localparam logic [4:0] ERR_EXT_ABORT = 5'h10;
  localparam logic [4:0] ERR_SOFT_ABORT = 5'h11;
  // limited-rate request interval
  localparam int CLK_PERIOD_NS = 40;
  localparam int LIMIT_PERIOD_NS = 640;
  localparam int LIMIT_CYCLES = (LIMIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] LIMIT_LAST = 8'(LIMIT_CYCLES - 1);
  // register layouts, msb first
  typedef struct packed {
    logic [5:0] zero;
    logic [1:0] level;
  } dccr_prio_t;
  typedef struct packed {
    logic [1:0] askMode;
    logic [1:0] protocol;
    logic width;
    logic [2:0] lineFunc;
  } dccr_devcfg_t;
  typedef struct packed {
    logic dir;
    logic zero;
    logic [1:0] size;
    logic [1:0] chain;
    logic [1:0] reqSrc;
  } dccr_opcfg_t;
  typedef struct packed {
    logic [3:0] zero;
    logic [1:0] memStep;
    logic [1:0] devStep;
  } dccr_seqcfg_t;
  typedef struct packed {
    logic go;
    logic cont;
    logic susp;
    logic abort;
    logic ien;
    logic [2:0] zero;
  } dccr_cmd_t;
  typedef struct packed {
    logic complete;
    logic blockDone;
    logic devTerm;
    logic err;
    logic running;
    logic reloaded;
    logic fallFlag;
    logic level;
  } dccr_status_t;
  // system bus strobes for one channel
  typedef struct packed {
    logic addrStrobe_n;
    logic selStrobe_n;
    logic dataStrobe_n;
    logic deviceCycle;
    logic readNotWrite;
  } dccr_bus_t;
  // pulses towards the address and count registers
  typedef struct packed {
    logic operandDone;
    logic memAdvance;
    logic devAdvance;
    logic [1:0] memBytes;
    logic [1:0] devBytes;
    logic reloadBase;
  } dccr_step_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_CYC1 = 5'b00010,
    S_TURN = 5'b00100,
    S_CYC2 = 5'b01000,
    S_GAP = 5'b10000
  } dccr_state_t;
endpackage

// >>> core/dccr_sync.sv
module dccr_sync import dccr_pkg::*; #(
  parameter int W = 1
) (
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous inputs
  output logic [W-1:0] q // synchronised copy
);
  logic [W-1:0] meta_r;

  // two flops, idle level high for active-low pins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '1;
      q <= '1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// >>> core/dccr_cfgchk.sv
module dccr_cfgchk import dccr_pkg::*; (
  input wire dccr_prio_t prio, // priority register
  input wire dccr_devcfg_t devcfg, // device configuration
  input wire dccr_opcfg_t opcfg, // operation configuration
  input wire dccr_seqcfg_t seqcfg, // address sequencing
  output logic cfgBad // a reserved code is programmed
);
  logic lineBad;
  logic askBad;

  // line function only matters without the ready protocol
  assign lineBad = (devcfg.protocol != PROTO_SELRDY) && !(devcfg.lineFunc == LINE_STATUS ||
    devcfg.lineFunc == LINE_STATUS_IRQ || devcfg.lineFunc == LINE_ABORT ||
    devcfg.lineFunc == LINE_RELOAD); // R10 R8
  // ask mode is ignored for internal request sources
  assign askBad = (opcfg.reqSrc == REQ_EXT) &&
    !(devcfg.askMode == ASK_BURST || devcfg.askMode == ASK_STEAL); // R2 R15

  // any reserved code fails the start
  assign cfgBad = !(prio.level == PRIO_0 || prio.level == PRIO_1) || // R1
    askBad || lineBad || !(devcfg.protocol == PROTO_EXPLICIT || // R4 R23
    devcfg.protocol == PROTO_SEL || devcfg.protocol == PROTO_SELRDY) ||
    !(opcfg.size == SIZE_BYTE || opcfg.size == SIZE_WORD) || // R13
    (opcfg.chain != CHAIN_OFF) || // R14
    !(opcfg.reqSrc == REQ_LIMITED || opcfg.reqSrc == REQ_MAX || opcfg.reqSrc == REQ_EXT) ||
    !(seqcfg.memStep == STEP_HOLD || seqcfg.memStep == STEP_UP) || // R16
    !(seqcfg.devStep == STEP_HOLD || seqcfg.devStep == STEP_UP);
endmodule

// >>> core/dccr_top.sv
// Notes on behaviour
// R1: priority codes 00 and 01; others reserved
// R2: ask mode 00 burst, 10 cycle steal
// R3: burst follows level; steal needs one edge each
// R4: protocol 00 explicit, 10 select, 11 select+ready
// R5: explicit devices use two bus cycles
// R6: implicit devices: select strobe, memory address
// R7: select-only cycles end on memory acknowledge
// R8: ready protocol gates strobes, ignores line bits
// R9: width bit: clear 8-bit, set 16-bit port
// R10: line function 000,001,011,100; others reserved
// R11: line level readable; falling edge flags, aborts, reloads
// R12: direction 0 memory to device, 1 reverse
// R13: operand size 00 byte, 01 word
// R14: chaining writable; non-zero fails start
// R15: request source 00 limited, 01 max, 10 external
// R16: address steps hold or count up
// R17: start self-clears; continue clears at end
// R18: start with continue pending is timing error
// R19: config writes after start are timing errors
// R20: halt suspends, soft abort terminates
// R21: interrupt on complete, block done, line fall
// R22: start reads zero; status shows running
// R23: reserved codes fail the start
// R24: illegal write errors and aborts channel
module dccr_top import dccr_pkg::*; (
  input wire logic sys_clk, // 25 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire logic hostCs_n, // register select pin
  input wire logic hostDs_n, // host data strobe pin
  input wire logic hostRw, // 1 read, 0 write
  input wire logic [5:0] hostAddr, // register offset
  input wire logic [7:0] hostWrData, // host write data
  output logic [7:0] hostDataOut, // host read data
  output logic hostDataOe, // read data drive enable
  output logic hostDtack_n, // host cycle acknowledge
  output logic irq_n, // interrupt request, active low
  input wire logic ask_n, // peripheral transfer request pin
  input wire logic peripheral_control_line, // control line pin
  input wire logic transfer_acknowledge_in, // memory acknowledge pin, active low
  input wire logic busOwned, // channel owns the bus
  input wire logic lastOperand, // operand counter is at one
  output dccr_bus_t bus, // bus cycle strobes
  output dccr_step_t step, // address and count pulses
  output logic [1:0] prioLevel // priority towards arbitration
);
  logic [4:0] pinsSync;
  logic csS, dsS, askS, lineS, ackS;
  logic lineDly_r, askDly_r, hostBusy_r;
  logic hostStrobe, accessPulse, wrPulse, rdPulse;
  logic wrDev, wrOp, wrSeq, wrPrio, wrCmd, wrStatus, illegalWr;
  dccr_prio_t prio_r;
  dccr_devcfg_t devcfg_r;
  dccr_opcfg_t opcfg_r;
  dccr_seqcfg_t seqcfg_r;
  dccr_cmd_t cmd_r, wdCmd;
  dccr_status_t status_r, wdStatus, statusRd;
  logic [4:0] errCode_r, errNew;
  logic startPulse_r, startReq, startTiming, cfgBad, errEvent;
  logic softAbortNow, extAbortNow, lineActive, lineFall, reloadNow;
  logic opDone, normalEnd, blockEnd, wantXfer, dual, rdyWait, readyGo_r;
  logic askPend_r, limPend_r, limTick, intStatusIrq;
  logic [7:0] limCnt_r, rdNxt;
  dccr_state_t state_r, stateNxt;

  // select, strobe, request, line and acknowledge pins pass two flops first
  dccr_sync #(.W(5)) uSync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .d({hostCs_n, hostDs_n, ask_n, peripheral_control_line, transfer_acknowledge_in}),
    .q(pinsSync)
  );
  assign {csS, dsS, askS, lineS, ackS} = pinsSync;

  dccr_cfgchk uChk (
    .prio(prio_r),
    .devcfg(devcfg_r),
    .opcfg(opcfg_r),
    .seqcfg(seqcfg_r),
    .cfgBad(cfgBad)
  );

  // host access: one pulse per strobe, address and data stable meanwhile
  assign hostStrobe = !csS && !dsS;
  assign accessPulse = hostStrobe && !hostBusy_r;
  assign wrPulse = accessPulse && !hostRw;
  assign rdPulse = accessPulse && hostRw;
  assign wdCmd = dccr_cmd_t'(hostWrData);
  assign wdStatus = dccr_status_t'(hostWrData);
  assign wrCmd = wrPulse && hostAddr == OFS_CMD;
  assign wrStatus = wrPulse && hostAddr == OFS_STATUS;
  assign wrDev = wrPulse && hostAddr == OFS_DEVCFG;
  assign wrOp = wrPulse && hostAddr == OFS_OPCFG;
  assign wrSeq = wrPulse && hostAddr == OFS_SEQCFG;
  assign wrPrio = wrPulse && hostAddr == OFS_PRIO;
  assign illegalWr = status_r.running && (wrDev || wrOp || wrSeq || wrPrio); // R19 R24

  // host handshake outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hostBusy_r <= 1'b0;
      hostDtack_n <= 1'b1;
      hostDataOe <= 1'b0;
    end else begin
      hostBusy_r <= hostStrobe;
      hostDtack_n <= !hostStrobe;
      hostDataOe <= hostStrobe && hostRw;
    end
  end

  // configuration registers, frozen while running
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prio_r <= dccr_prio_t'(REG_RESET);
      devcfg_r <= dccr_devcfg_t'(REG_RESET);
      opcfg_r <= dccr_opcfg_t'(REG_RESET);
      seqcfg_r <= dccr_seqcfg_t'(REG_RESET);
    end else if (!status_r.running) begin
      if (wrPrio) begin
        prio_r.level <= hostWrData[1:0]; // R1
      end
      if (wrDev) begin
        devcfg_r <= dccr_devcfg_t'(hostWrData); // R2 R4 R9 R10
      end
      if (wrOp) begin
        opcfg_r <= dccr_opcfg_t'(hostWrData & 8'hBF); // R14
      end
      if (wrSeq) begin
        seqcfg_r <= dccr_seqcfg_t'(hostWrData & 8'h0F);
      end
    end
  end

  // command register: go is never stored, continue cleared by hardware
  assign startReq = wrCmd && wdCmd.go;
  assign startTiming = startReq && (cmd_r.cont || status_r.running); // R18
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_r <= dccr_cmd_t'(REG_RESET);
      startPulse_r <= 1'b0;
    end else begin
      startPulse_r <= startReq && !startTiming; // R17
      if (wrCmd) begin
        cmd_r.susp <= wdCmd.susp; // R20
        cmd_r.abort <= wdCmd.abort;
        cmd_r.ien <= wdCmd.ien;
      end
      if (wrCmd && wdCmd.cont) begin
        cmd_r.cont <= 1'b1;
      end else if (blockEnd || errEvent) begin
        cmd_r.cont <= 1'b0; // R17
      end
    end
  end

  // control line: level, falling edge and its programmed use
  assign lineActive = devcfg_r.protocol != PROTO_SELRDY; // R8
  assign lineFall = lineDly_r && !lineS && lineActive; // R11
  assign extAbortNow = lineFall && devcfg_r.lineFunc == LINE_ABORT && status_r.running; // R11
  assign reloadNow = lineFall && devcfg_r.lineFunc == LINE_RELOAD; // R11
  assign softAbortNow = (wrCmd && wdCmd.abort && status_r.running) ||
    (startPulse_r && cmd_r.abort); // R20
  assign intStatusIrq = lineActive && devcfg_r.lineFunc == LINE_STATUS_IRQ;

  // first error wins the code; any error terminates
  always_comb begin
    errNew = ERR_NONE;
    if (startTiming || illegalWr) begin
      errNew = ERR_TIMING; // R18 R19 R24
    end else if (startPulse_r && cfgBad) begin
      errNew = ERR_CONFIG; // R14 R23
    end else if (startPulse_r && (status_r.complete || status_r.err)) begin
      errNew = ERR_TIMING;
    end else if (softAbortNow) begin
      errNew = ERR_SOFT_ABORT; // R20
    end else if (extAbortNow) begin
      errNew = ERR_EXT_ABORT; // R11
    end
  end
  assign errEvent = errNew != ERR_NONE;
  assign normalEnd = opDone && lastOperand && !cmd_r.cont;
  assign blockEnd = opDone && lastOperand && cmd_r.cont;

  // status flags: hardware set wins over a write-one clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      status_r <= dccr_status_t'(REG_RESET);
      errCode_r <= ERR_NONE;
      lineDly_r <= 1'b1;
    end else begin
      lineDly_r <= lineS;
      status_r.level <= lineS && lineActive; // R11 R8
      status_r.complete <= errEvent || normalEnd || (status_r.complete &&
        !(wrStatus && wdStatus.complete));
      status_r.blockDone <= blockEnd || (status_r.blockDone &&
        !(wrStatus && wdStatus.blockDone));
      status_r.fallFlag <= lineFall || (status_r.fallFlag &&
        !(wrStatus && wdStatus.fallFlag)); // R11
      status_r.reloaded <= reloadNow || (status_r.reloaded &&
        !(wrStatus && wdStatus.reloaded));
      if (errEvent && (errCode_r == ERR_NONE || (wrStatus && wdStatus.err))) begin
        errCode_r <= errNew;
      end else if (wrStatus && wdStatus.err) begin
        errCode_r <= ERR_NONE;
      end
      status_r.err <= errEvent || (status_r.err && !(wrStatus && wdStatus.err));
      if (errEvent || normalEnd) begin
        status_r.running <= 1'b0;
      end else if (startPulse_r) begin
        status_r.running <= 1'b1; // R22
      end
    end
  end

  // register read data, go always reads zero
  assign statusRd = status_r;
  always_comb begin
    case (hostAddr)
      OFS_STATUS: rdNxt = statusRd;
      OFS_ERROR: rdNxt = {3'h0, errCode_r};
      OFS_DEVCFG: rdNxt = devcfg_r;
      OFS_OPCFG: rdNxt = opcfg_r;
      OFS_SEQCFG: rdNxt = seqcfg_r;
      OFS_CMD: rdNxt = {1'b0, cmd_r[6:0]}; // R22
      OFS_PRIO: rdNxt = prio_r;
      default: rdNxt = NULL_READ;
    endcase
  end

  // read data and interrupt out of flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hostDataOut <= REG_RESET;
      irq_n <= 1'b1;
      prioLevel <= PRIO_0;
    end else begin
      if (rdPulse) begin
        hostDataOut <= rdNxt;
      end
      irq_n <= !(cmd_r.ien && (status_r.complete || status_r.blockDone ||
        (status_r.fallFlag && intStatusIrq))); // R21
      prioLevel <= prio_r.level;
    end
  end

  // request sources: limited-rate tick, steal edge, burst level
  assign limTick = limCnt_r == LIMIT_LAST;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      limCnt_r <= 8'h00;
      limPend_r <= 1'b0;
      askPend_r <= 1'b0;
      askDly_r <= 1'b1;
    end else begin
      limCnt_r <= limTick ? 8'h00 : limCnt_r + 8'h01;
      askDly_r <= askS;
      if (state_r == S_IDLE && stateNxt == S_CYC1) begin
        limPend_r <= 1'b0;
        askPend_r <= 1'b0;
      end else begin
        limPend_r <= limPend_r || limTick;
        askPend_r <= askPend_r || (askDly_r && !askS); // R3
      end
    end
  end

  assign dual = devcfg_r.protocol == PROTO_EXPLICIT; // R4 R5
  assign rdyWait = devcfg_r.protocol == PROTO_SELRDY && opcfg_r.dir; // R8
  always_comb begin
    case (opcfg_r.reqSrc)
      REQ_MAX: wantXfer = 1'b1; // R15
      REQ_LIMITED: wantXfer = limPend_r;
      REQ_EXT: wantXfer = devcfg_r.askMode == ASK_BURST ? !askS : askPend_r; // R3 R15
      default: wantXfer = 1'b0;
    endcase
  end

  // operand transfer sequence
  always_comb begin
    stateNxt = state_r;
    opDone = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (wantXfer && status_r.running && !cmd_r.susp && busOwned && !errEvent) begin
          stateNxt = S_CYC1; // R20
        end
      end
      S_CYC1: begin
        if (errEvent) begin
          stateNxt = S_GAP;
        end else if (rdyWait ? readyGo_r : !ackS) begin // R7 R8
          stateNxt = dual ? S_TURN : S_GAP; // R5 R6
          opDone = !dual;
        end
      end
      S_TURN: begin
        if (errEvent) begin
          stateNxt = S_GAP;
        end else if (ackS) begin
          stateNxt = S_CYC2; // R5
        end
      end
      S_CYC2: begin
        if (errEvent) begin
          stateNxt = S_GAP;
        end else if (!ackS) begin
          stateNxt = S_GAP;
          opDone = 1'b1;
        end
      end
      S_GAP: begin
        if (ackS) begin
          stateNxt = S_IDLE;
        end
      end
      default: stateNxt = S_IDLE;
    endcase
  end

  // state, ready latch and bus strobes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= S_IDLE;
      readyGo_r <= 1'b0;
      bus <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    end else begin
      state_r <= stateNxt;
      readyGo_r <= state_r == S_CYC1 && rdyWait && (readyGo_r || (!lineS && !ackS)); // R8
      bus.addrStrobe_n <= !(state_r == S_CYC1 || state_r == S_CYC2);
      bus.selStrobe_n <= !(state_r == S_CYC1 && !dual); // R6
      bus.deviceCycle <= dual && ((state_r == S_CYC1 && opcfg_r.dir) ||
        (state_r == S_CYC2 && !opcfg_r.dir)); // R5
      bus.readNotWrite <= dual && (state_r == S_CYC1) == opcfg_r.dir ? opcfg_r.dir :
        !opcfg_r.dir; // R12
      bus.dataStrobe_n <= !((state_r == S_CYC1 && (!rdyWait || readyGo_r)) ||
        state_r == S_CYC2); // R8
    end
  end

  // address and count pulses
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      step <= '0;
    end else begin
      step.operandDone <= opDone;
      step.memAdvance <= opDone && seqcfg_r.memStep == STEP_UP; // R16
      step.devAdvance <= opDone && dual && seqcfg_r.devStep == STEP_UP; // R16
      step.memBytes <= opcfg_r.size == SIZE_WORD ? BYTES_2 : BYTES_1; // R13
      step.devBytes <= devcfg_r.width ? (opcfg_r.size == SIZE_WORD ? BYTES_2 : BYTES_1) :
        BYTES_2; // R9
      step.reloadBase <= reloadNow || blockEnd; // R11
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_cleanStart;
    wrCmd && wdCmd.go && !cmd_r.cont && !status_r.running && !cfgBad && !cmd_r.abort &&
      !status_r.complete && !status_r.err && !wrStatus;
  endsequence
  property p_startRuns;
    s_cleanStart |=> startPulse_r ##1 status_r.running && !startPulse_r;
  endproperty
  a_startRuns: assert property (p_startRuns) else $error("clean start did not run"); // R17 R22
  property p_goReadsZero;
    rdPulse && hostAddr == OFS_CMD |=> !hostDataOut[7];
  endproperty
  a_goReadsZero: assert property (p_goReadsZero) else $error("go bit read as one"); // R22
  property p_contStart;
    wrCmd && wdCmd.go && cmd_r.cont |=> status_r.err && !startPulse_r;
  endproperty
  a_contStart: assert property (p_contStart) else $error("no timing error"); // R18
  property p_cfgLocked;
    status_r.running && wrDev |=> $stable(devcfg_r) && !status_r.running && status_r.err;
  endproperty
  a_cfgLocked: assert property (p_cfgLocked) else $error("locked write accepted"); // R19 R24
  property p_cfgErr;
    startPulse_r && cfgBad |=> !status_r.running && status_r.err && status_r.complete;
  endproperty
  a_cfgErr: assert property (p_cfgErr) else $error("reserved code started"); // R23
  property p_halt;
    cmd_r.susp && state_r == S_IDLE |=> state_r == S_IDLE;
  endproperty
  a_halt: assert property (p_halt) else $error("cycle began while halted"); // R20
  property p_irq;
    cmd_r.ien && status_r.complete |=> !irq_n;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing"); // R21
  property p_single;
    state_r == S_CYC1 && !dual |=> !bus.selStrobe_n && !bus.addrStrobe_n;
  endproperty
  a_single: assert property (p_single) else $error("select strobe missing"); // R6
  property p_dual;
    state_r == S_TURN |-> dual;
  endproperty
  a_dual: assert property (p_dual) else $error("second cycle without explicit device"); // R5
endmodule

// >>> sim/dccr_mem_model.sv
module dccr_mem_model import dccr_pkg::*; (
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire dccr_bus_t bus, // strobes from the channel
  input wire logic [3:0] waitCycles, // acknowledge latency in cycles
  output logic ackN // transfer acknowledge, active low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  // acknowledge after the chosen latency, release with the address strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      ackN <= 1'h1;
    end else if (bus.addrStrobe_n) begin
      cnt <= 4'h0;
      ackN <= 1'h1;
    end else if (cnt >= waitCycles) begin
      ackN <= 1'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// >>> sim/tb_top.sv
module tb_top import dccr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, nrst, hostCs_n, hostDs_n, hostRw, busOwned, prevAs, devSeen, selSeen;
  logic [5:0] hostAddr;
  logic [7:0] hostWrData, hostDataOut;
  logic hostDataOe, hostDtack_n, irq_n, ackN, askN, pclLine;
  logic [3:0] waitCycles;
  dccr_bus_t bus;
  dccr_step_t step;
  logic [1:0] prioLevel;
  int failures, checks_done, falls, ops;
  logic [5:0] badOfs [8] = '{OFS_PRIO, OFS_DEVCFG, OFS_DEVCFG, OFS_DEVCFG, OFS_OPCFG,
    OFS_OPCFG, OFS_OPCFG, OFS_SEQCFG};
  logic [7:0] badVal [8] = '{8'h02, 8'h40, 8'h10, 8'h02, 8'h20, 8'h04, 8'h03, 8'h08};
  logic [5:0] cfgOfs [5] = '{OFS_PRIO, OFS_DEVCFG, OFS_OPCFG, OFS_SEQCFG, OFS_CMD};
  dccr_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .hostCs_n(hostCs_n), .hostDs_n(hostDs_n),
    .hostRw(hostRw), .hostAddr(hostAddr), .hostWrData(hostWrData), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe), .hostDtack_n(hostDtack_n), .irq_n(irq_n), .ask_n(askN),
    .peripheral_control_line(pclLine), .transfer_acknowledge_in(ackN), .busOwned(busOwned),
    .lastOperand(1'h1), .bus(bus), .step(step), .prioLevel(prioLevel));
  dccr_mem_model mem_u (.sys_clk(sys_clk), .nrst(nrst), .bus(bus), .waitCycles(waitCycles),
    .ackN(ackN));
  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end
  // watch the bus strobes away from the sampling edge
  always @(negedge sys_clk) begin
    if (prevAs === 1'h1 && bus.addrStrobe_n === 1'h0) falls++;
    prevAs = bus.addrStrobe_n;
    if (bus.deviceCycle === 1'h1 && bus.readNotWrite === 1'h0) devSeen = 1'h1;
    if (bus.selStrobe_n === 1'h0 && bus.dataStrobe_n === 1'h0) selSeen = 1'h1;
    if (step.operandDone === 1'h1) ops++;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  // one host access: hold strobes until acknowledge, then release
  task automatic hostCycle(input logic rw, input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    @(posedge sys_clk);
    hostCs_n <= 1'h0;
    hostDs_n <= 1'h0;
    hostRw <= rw;
    hostAddr <= a;
    hostWrData <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (hostDtack_n !== 1'h0 && n < 20);
    if (hostDtack_n !== 1'h0) n = 40;
    q = hostDataOut;
    check("data enable", {7'h00, rw}, {7'h00, hostDataOe});
    @(posedge sys_clk);
    hostCs_n <= 1'h1;
    hostDs_n <= 1'h1;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (hostDtack_n !== 1'h1 && n < 40);
    if (n >= 40) begin
      check("host acknowledge wait", 8'h00, 8'h01);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    hostCycle(1'h0, a, d, q);
  endtask
  task automatic rd(input string what, input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    hostCycle(1'h1, a, 8'h00, q);
    check(what, exp, q);
  endtask
  // start with interrupts on, grant the bus, wait for completion
  task automatic runXfer(input logic [7:0] dev, input logic hold, input int expFalls,
    input logic expDev, input logic expSel);
    logic [7:0] q;
    wr(OFS_DEVCFG, dev);
    wr(OFS_CMD, hold ? 8'hA8 : 8'h88);
    falls = 0;
    ops = 0;
    devSeen = 1'h0;
    selSeen = 1'h0;
    @(posedge sys_clk);
    busOwned <= 1'h1;
    if (hold) begin
      repeat (30) @(posedge sys_clk);
      check("strobes while halted", 8'h00, 8'(falls));
      askN <= 1'h0;
      repeat (4) @(posedge sys_clk);
      askN <= 1'h1;
      wr(OFS_CMD, 8'h08);
    end
    q = 8'h00;
    for (int i = 0; i < 20 && q[7] !== 1'h1; i++) hostCycle(1'h1, OFS_STATUS, 8'h00, q);
    @(posedge sys_clk);
    busOwned <= 1'h0;
    check("status at end", 8'h81, q);
    check("address strobe falls", 8'(expFalls), 8'(falls));
    check("device cycle seen", {7'h00, expDev}, {7'h00, devSeen});
    check("select seen", {7'h00, expSel}, {7'h00, selSeen});
    check("operand pulses", 8'h01, 8'(ops));
    check("irq on complete", 8'h00, {7'h00, irq_n});
    wr(OFS_STATUS, 8'hFF);
    check("irq after clear", 8'h01, {7'h00, irq_n});
  endtask
  initial begin
    {nrst, busOwned, falls, checks_done, failures} = '0;
    {hostCs_n, hostDs_n, hostRw, prevAs, askN, pclLine} = 6'h3F;
    hostAddr = 6'h00;
    hostWrData = 8'h00;
    waitCycles = 4'h2;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'h1;
    foreach (cfgOfs[i]) rd("reset value", cfgOfs[i], REG_RESET);
    rd("unmapped read", 6'h3F, NULL_READ);
    wr(OFS_PRIO, 8'h01);
    rd("priority", OFS_PRIO, 8'h01);
    check("priority out", 8'h01, {6'h00, prioLevel});
    wr(OFS_DEVCFG, 8'hBC);
    rd("device config", OFS_DEVCFG, 8'hBC);
    wr(OFS_OPCFG, 8'h96);
    rd("operation config", OFS_OPCFG, 8'h96);
    wr(OFS_SEQCFG, 8'h05);
    rd("sequence config", OFS_SEQCFG, 8'h05);
    foreach (cfgOfs[i]) wr(cfgOfs[i], 8'h00);
    wr(OFS_OPCFG, 8'h02);
    foreach (badOfs[i]) begin
      wr(badOfs[i], badVal[i]);
      wr(OFS_CMD, 8'h80);
      rd("config error", OFS_ERROR, {3'h0, ERR_CONFIG});
      rd("status after bad start", OFS_STATUS, 8'h91);
      wr(badOfs[i], 8'h00);
      wr(OFS_STATUS, 8'hFF);
    end
    wr(OFS_OPCFG, 8'h01);
    wr(OFS_CMD, 8'h80);
    rd("running status", OFS_STATUS, 8'h09);
    rd("start reads zero", OFS_CMD, 8'h00);
    wr(OFS_DEVCFG, 8'h20);
    rd("timing error", OFS_ERROR, {3'h0, ERR_TIMING});
    rd("status after write", OFS_STATUS, 8'h91);
    rd("config kept", OFS_DEVCFG, 8'h00);
    wr(OFS_STATUS, 8'hFF);
    wr(OFS_CMD, 8'h40);
    wr(OFS_CMD, 8'h80);
    rd("continue pending start", OFS_ERROR, {3'h0, ERR_TIMING});
    rd("continue cleared", OFS_CMD, 8'h00);
    wr(OFS_STATUS, 8'hFF);
    wr(OFS_CMD, 8'h80);
    wr(OFS_CMD, 8'h10);
    rd("soft abort", OFS_ERROR, {3'h0, ERR_SOFT_ABORT});
    wr(OFS_CMD, 8'h00);
    wr(OFS_STATUS, 8'hFF);
    runXfer(8'h00, 1'h0, 2, 1'h1, 1'h0);
    runXfer(8'h20, 1'h0, 1, 1'h0, 1'h1);
    @(posedge sys_clk);
    waitCycles <= 4'h7;
    runXfer(8'h20, 1'h1, 1, 1'h0, 1'h1);
    wr(OFS_OPCFG, 8'h02);
    @(posedge sys_clk);
    askN <= 1'h0;
    runXfer(8'h00, 1'h0, 2, 1'h1, 1'h0);
    @(posedge sys_clk);
    askN <= 1'h1;
    runXfer(8'hA0, 1'h1, 1, 1'h0, 1'h1);
    wr(OFS_DEVCFG, 8'h03);
    wr(OFS_CMD, 8'h80);
    @(posedge sys_clk);
    pclLine <= 1'h0;
    rd("line abort", OFS_ERROR, {3'h0, ERR_EXT_ABORT});
    rd("status after line abort", OFS_STATUS, 8'h92);
    @(posedge sys_clk);
    pclLine <= 1'h1;
    wr(OFS_STATUS, 8'hFF);
    wr(OFS_DEVCFG, 8'h04);
    @(posedge sys_clk);
    pclLine <= 1'h0;
    rd("reload flag", OFS_STATUS, 8'h06);
    @(posedge sys_clk);
    pclLine <= 1'h1;
    wr(OFS_STATUS, 8'hFF);
    wr(OFS_OPCFG, 8'h01);
    wr(OFS_CMD, 8'hC0);
    @(posedge sys_clk);
    busOwned <= 1'h1;
    repeat (100) @(posedge sys_clk);
    busOwned <= 1'h0;
    rd("block then end", OFS_STATUS, 8'hC1);
    rd("continue cleared at end", OFS_CMD, 8'h00);
    tally_and_finish();
  end
endmodule
